// ---- design/prc_reset_pd_ctrl.sv ----
// prc_reset_pd_ctrl: reset sources and power-down modes of the phy core.
// assumes all pins synchronous to core_clk, management port single cycle.
//
// Summary of operation
// - hardware reset pin low holds the device in hardware reset.
// - leaving hardware reset restores register defaults and relatches straps.
// - soft reset bit starts reset, clears itself about 256 us later.
// - soft reset clears logic except bits marked exempt from soft reset.
// - after soft reset configuration comes from registers, straps not resampled.
// - leaving any power-down gives a power-down reset; registers kept.
// - power-down reset never relatches straps or configuration pins.
// - power-down reset held 256 us after exit for pll settling.
// - power down bit set keeps everything but management powered down.
// - clearing power down bit powers up with a power-down reset.
// - energy-detect sleep transmits nothing, only squelch and detect stay on.
// - line energy sets status bit, wakes, restores, stays on with energy.
// - energy mask set asserts interrupt on an energy wake-up.
// - first one or two packets on an energy wake-up may be lost.
// - hardware power-down pin keeps all but management powered down.
// - latched pll strap decides pll shutdown in hardware power-down.
// - power-down pin held through hardware reset wakes into power-down.
// - strap low shuts pll off in power-down, strap high keeps it in pin power-down only.
// - straps captured just after hardware reset release, used as defaults.
`timescale 1ns/10ps
module prc_reset_pd_ctrl #(
    parameter int SRST_CYCLES = prc_pkg::PRC_SRST_CYCLES,
    parameter int PDX_CYCLES = prc_pkg::PRC_PDX_CYCLES
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic hw_reset_in_n,
    input wire logic hw_powerdown_pin,
    input wire logic hw_pd_pll_select_strap,
    input wire logic [prc_pkg::PRC_CW-1:0] cfg_pins,
    input wire logic line_energy_in,
    input wire prc_pkg::prc_bus_req_t bus_req,
    output prc_pkg::prc_word_t rd_data,
    output prc_pkg::prc_pwr_t pwr,
    output logic strap_latched,
    output logic [prc_pkg::PRC_CW-1:0] cfg_latched,
    output logic irq_n
);
    import prc_pkg::*;

    typedef struct packed {
        prc_state_t state;
        prc_word_t ctrl;
        logic edpd_en;
        logic energy;
        logic energy_flag;
        logic energy_mask;
        prc_word_t keep;
        logic strap;
        logic [PRC_CW-1:0] cfg;
        logic sr_go;
        logic px_go;
        prc_word_t rd_data;
        prc_pwr_t pwr;
        logic irq_n;
    } prc_core_t;

    prc_core_t core_reg;
    prc_core_t core_next;

    logic sr_busy;
    logic sr_done;
    logic px_busy;
    logic px_done;

    ////////////////////////////////////////////////////////////////////////
    // reset duration timers on the free-running clock
    // free-running timing
    prc_timer #(
        .CYCLES(SRST_CYCLES)
    ) u_srst_timer (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .start(core_reg.sr_go),
        .busy(sr_busy),
        .done(sr_done)
    );

    prc_timer #(
        .CYCLES(PDX_CYCLES)
    ) u_pdx_timer (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .start(core_reg.px_go),
        .busy(px_busy),
        .done(px_done)
    );

    ////////////////////////////////////////////////////////////////////////
    // next-state logic
    always_comb begin
        core_next = core_reg;
        core_next.sr_go = 1'b0;
        core_next.px_go = 1'b0;
        core_next.rd_data = PRC_ZERO;
        core_next.energy = line_energy_in;
        if (!hw_reset_in_n) begin
            core_next.state = ST_HWRST;
            core_next.ctrl = PRC_CTRL_RST;
            core_next.edpd_en = 1'b0;
            core_next.energy = PRC_ENERGY_RST;
            core_next.energy_flag = 1'b0;
            core_next.energy_mask = 1'b0;
            core_next.keep = PRC_KEEP_RST;
        end else begin
            // register writes
            if (bus_req.wr) begin
                case (bus_req.addr)
                    PRC_REG_CTRL: core_next.ctrl = bus_req.wdata;
                    PRC_REG_EDCS: begin
                        core_next.edpd_en = bus_req.wdata[PRC_EDCS_EDPD_BIT];
                    end
                    PRC_REG_MASK: begin
                        core_next.energy_mask =
                            bus_req.wdata[PRC_EVT_ENERGY_BIT];
                    end
                    PRC_REG_KEEP: core_next.keep = bus_req.wdata;
                    default: ;
                endcase
            end
            // register reads, flag register clears on read
            if (bus_req.rd) begin
                case (bus_req.addr)
                    PRC_REG_CTRL: core_next.rd_data = core_reg.ctrl;
                    PRC_REG_STAT: begin
                        core_next.rd_data[PRC_STAT_STRAP_BIT] = core_reg.strap;
                        core_next.rd_data[PRC_STAT_CFG_LSB +: PRC_CW] =
                            core_reg.cfg;
                        core_next.rd_data[PRC_STAT_PD_BIT] =
                            (core_reg.state == ST_PD);
                        core_next.rd_data[PRC_STAT_EDPD_BIT] =
                            (core_reg.state == ST_EDPD);
                        core_next.rd_data[PRC_STAT_HWPD_BIT] =
                            hw_powerdown_pin;
                    end
                    PRC_REG_EDCS: begin
                        core_next.rd_data[PRC_EDCS_EDPD_BIT] =
                            core_reg.edpd_en;
                        core_next.rd_data[PRC_EDCS_ENERGY_BIT] =
                            core_reg.energy;
                    end
                    PRC_REG_FLAG: begin
                        core_next.rd_data[PRC_EVT_ENERGY_BIT] =
                            core_reg.energy_flag;
                        core_next.energy_flag = 1'b0;
                    end
                    PRC_REG_MASK: begin
                        core_next.rd_data[PRC_EVT_ENERGY_BIT] =
                            core_reg.energy_mask;
                    end
                    PRC_REG_KEEP: core_next.rd_data = core_reg.keep;
                    default: core_next.rd_data = PRC_ZERO;
                endcase
            end
            // sequencer
            case (core_reg.state)
                ST_HWRST: begin
                    core_next.strap = hw_pd_pll_select_strap;
                    core_next.cfg = cfg_pins;
                    if (hw_powerdown_pin) begin
                        core_next.state = ST_PD;
                        core_next.ctrl[PRC_CTRL_PD_BIT] = 1'b1;
                    end else begin
                        core_next.state = ST_RUN;
                    end
                end
                ST_RUN: begin
                    if (core_reg.ctrl[PRC_CTRL_SRST_BIT]) begin
                        core_next.state = ST_SOFTRST;
                        core_next.sr_go = 1'b1;
                        core_next.ctrl = PRC_CTRL_RST;
                        core_next.ctrl[PRC_CTRL_SRST_BIT] = 1'b1;
                        core_next.edpd_en = 1'b0;
                        core_next.energy_flag = 1'b0;
                        core_next.energy_mask = 1'b0;
                    end else if (core_reg.ctrl[PRC_CTRL_PD_BIT] ||
                                 hw_powerdown_pin) begin
                        core_next.state = ST_PD;
                        core_next.ctrl[PRC_CTRL_PD_BIT] = 1'b1;
                    end else if (core_reg.edpd_en && !line_energy_in) begin
                        core_next.state = ST_EDPD;
                    end
                end
                ST_SOFTRST: begin
                    core_next.ctrl[PRC_CTRL_SRST_BIT] = 1'b1;
                    if (sr_done) begin
                        core_next.ctrl[PRC_CTRL_SRST_BIT] = 1'b0;
                        core_next.state = ST_RUN;
                    end
                end
                ST_PD: begin
                    if (hw_powerdown_pin) begin
                        core_next.ctrl[PRC_CTRL_PD_BIT] = 1'b1;
                    end else if (!core_next.ctrl[PRC_CTRL_PD_BIT]) begin
                        core_next.state = ST_PDRST;
                        core_next.px_go = 1'b1;
                    end
                end
                ST_EDPD: begin
                    if (core_reg.ctrl[PRC_CTRL_PD_BIT] || hw_powerdown_pin) begin
                        core_next.state = ST_PD;
                        core_next.ctrl[PRC_CTRL_PD_BIT] = 1'b1;
                    end else if (line_energy_in || !core_reg.edpd_en) begin
                        core_next.state = ST_PDRST;
                        core_next.px_go = 1'b1;
                        // set wins over a clear on read
                        if (line_energy_in) begin
                            core_next.energy_flag = 1'b1;
                        end
                    end
                end
                ST_PDRST: begin
                    if (px_done) begin
                        core_next.state = ST_RUN;
                    end
                end
                default: core_next.state = ST_HWRST;
            endcase
        end
        // power controls from the coming state
        // nothing sent while asleep
        core_next.pwr.tx_en = (core_next.state == ST_RUN);
        core_next.pwr.core_reset_n = (core_next.state == ST_RUN) ||
            (core_next.state == ST_PD) || (core_next.state == ST_EDPD);
        core_next.pwr.core_power_en = (core_next.state != ST_PD) &&
            (core_next.state != ST_EDPD);
        core_next.pwr.squelch_en = (core_next.state != ST_PD);
        // pll follows latched strap in hardware power-down
        // strap low shuts the pll off
        core_next.pwr.pll_en = core_next.pwr.core_power_en ||
            ((core_next.state == ST_PD) && hw_powerdown_pin &&
             core_next.strap);
        core_next.irq_n = !(core_next.energy_flag && core_next.energy_mask);
    end

    ////////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            core_reg <= '0;
            core_reg.state <= ST_HWRST;
            core_reg.energy <= PRC_ENERGY_RST;
            core_reg.irq_n <= 1'b1;
        end else begin
            core_reg <= core_next;
        end
    end

    // outputs straight from the state register
    assign rd_data = core_reg.rd_data;
    assign pwr = core_reg.pwr;
    assign strap_latched = core_reg.strap;
    assign cfg_latched = core_reg.cfg;
    assign irq_n = core_reg.irq_n;

    ////////////////////////////////////////////////////////////////////////
    // checks
    // hardware reset holds
    hw_reset_hold_a: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        !hw_reset_in_n |=> (core_reg.state == ST_HWRST) &&
            !pwr.core_reset_n && (core_reg.ctrl == PRC_CTRL_RST))
        else $error("hardware reset not applied");

    strap_capture_a: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        (core_reg.state == ST_HWRST) && hw_reset_in_n |=>
            strap_latched == $past(hw_pd_pll_select_strap))
        else $error("strap not captured at reset release");

    // straps stay through soft and power-down resets
    strap_hold_a: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        (core_reg.state inside {ST_SOFTRST, ST_PDRST}) |=>
            $stable(strap_latched) && $stable(cfg_latched))
        else $error("strap relatched outside hardware reset");

    // bit clears when the timer ends
    srst_clear_a: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        (core_reg.state == ST_SOFTRST) && sr_done && hw_reset_in_n |=>
            !core_reg.ctrl[PRC_CTRL_SRST_BIT] && (core_reg.state == ST_RUN))
        else $error("soft reset bit did not clear");

    keep_exempt_a: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        (core_reg.state == ST_RUN) && core_reg.ctrl[PRC_CTRL_SRST_BIT] &&
            hw_reset_in_n && !bus_req.wr |=> $stable(core_reg.keep) &&
            core_reg.sr_go && !core_reg.energy_mask ##1 sr_busy)
        else $error("soft reset disturbed exempt bits");

    // leaving power-down goes through the extended reset
    pd_exit_rst_a: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        (core_reg.state inside {ST_PD, ST_EDPD}) ##1
            !(core_reg.state inside {ST_PD, ST_EDPD, ST_HWRST}) |->
            (core_reg.state == ST_PDRST) ##1 px_busy)
        else $error("power-down exit without reset");

    pd_power_off_a: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        (core_reg.state == ST_PD) |-> !pwr.core_power_en && !pwr.tx_en &&
            !pwr.squelch_en)
        else $error("core powered in power-down");

    edpd_quiet_a: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        (core_reg.state == ST_EDPD) |-> !pwr.tx_en && pwr.squelch_en &&
            !pwr.pll_en)
        else $error("energy sleep not quiet");

    energy_irq_a: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        (core_reg.state == ST_EDPD) && line_energy_in && hw_reset_in_n &&
            !hw_powerdown_pin && !core_reg.ctrl[PRC_CTRL_PD_BIT] &&
            core_reg.energy_mask && !bus_req.wr |=>
            core_reg.energy_flag && !irq_n)
        else $error("energy wake without interrupt");

    // strap low keeps the pll off in pin power-down
    pll_strap_a: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        (core_reg.state == ST_PD) && $past(hw_powerdown_pin) &&
            !strap_latched |-> !pwr.pll_en)
        else $error("pll running against strap");

endmodule

// ---- design/prc_pkg.sv ----
// prc_pkg: shared constants and types for the phy reset and power-down
// controller; assumes a 50 MHz free-running core clock.
package prc_pkg;

    ////////////////////////////////////////////////////////////////////////
    // widths
    localparam int PRC_DW = 16;
    localparam int PRC_AW = 5;
    localparam int PRC_CW = 4;
    localparam int PRC_TW = 16;

    typedef logic [PRC_DW-1:0] prc_word_t;
    typedef logic [PRC_AW-1:0] prc_addr_t;
    typedef logic [PRC_TW-1:0] prc_count_t;

    ////////////////////////////////////////////////////////////////////////
    // register offsets (register index on the management port)
    localparam prc_addr_t PRC_REG_CTRL = 5'h00;
    localparam prc_addr_t PRC_REG_STAT = 5'h10;
    localparam prc_addr_t PRC_REG_EDCS = 5'h11;
    localparam prc_addr_t PRC_REG_FLAG = 5'h1d;
    localparam prc_addr_t PRC_REG_MASK = 5'h1e;
    localparam prc_addr_t PRC_REG_KEEP = 5'h1f;

    // field positions
    localparam int PRC_CTRL_SRST_BIT = 15;
    localparam int PRC_CTRL_PD_BIT = 11;
    localparam int PRC_EDCS_EDPD_BIT = 13;
    localparam int PRC_EDCS_ENERGY_BIT = 1;
    localparam int PRC_EVT_ENERGY_BIT = 7;
    localparam int PRC_STAT_STRAP_BIT = 0;
    localparam int PRC_STAT_CFG_LSB = 1;
    localparam int PRC_STAT_PD_BIT = 5;
    localparam int PRC_STAT_EDPD_BIT = 6;
    localparam int PRC_STAT_HWPD_BIT = 7;

    // reset values
    localparam prc_word_t PRC_CTRL_RST = 16'h0000;
    localparam prc_word_t PRC_KEEP_RST = 16'h0000;
    localparam prc_word_t PRC_ZERO = 16'h0000;
    localparam logic PRC_ENERGY_RST = 1'h1;

    ////////////////////////////////////////////////////////////////////////
    // timing
    localparam int PRC_CLK_PERIOD_NS = 20;
    localparam int PRC_SRST_TIME_NS = 256000;
    localparam int PRC_PDX_TIME_NS = 256000;
    // least times, so round up
    localparam int PRC_SRST_CYCLES =
        (PRC_SRST_TIME_NS + PRC_CLK_PERIOD_NS - 1) / PRC_CLK_PERIOD_NS;
    localparam int PRC_PDX_CYCLES =
        (PRC_PDX_TIME_NS + PRC_CLK_PERIOD_NS - 1) / PRC_CLK_PERIOD_NS;

    ////////////////////////////////////////////////////////////////////////
    // types
    typedef enum logic [2:0] {
        ST_HWRST, ST_RUN, ST_SOFTRST, ST_PD, ST_EDPD, ST_PDRST
    } prc_state_t;

    typedef struct packed {
        logic wr;
        logic rd;
        prc_addr_t addr;
        prc_word_t wdata;
    } prc_bus_req_t;

    typedef struct packed {
        logic core_reset_n;
        logic core_power_en;
        logic pll_en;
        logic tx_en;
        logic squelch_en;
    } prc_pwr_t;

endpackage

// ---- design/prc_timer.sv ----
// prc_timer: one-shot down counter on the free-running core clock.
// assumes start is a single-cycle pulse; a start while busy restarts it.
`timescale 1ns/10ps
module prc_timer #(
    parameter int CYCLES = 16
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic start,
    output logic busy,
    output logic done
);
    import prc_pkg::*;

    typedef struct packed {
        logic busy;
        prc_count_t cnt;
    } prc_tmr_state_t;

    localparam prc_count_t LOAD = prc_count_t'(CYCLES - 1);
    localparam prc_count_t ONE = 16'h0001;

    prc_tmr_state_t tmr_reg;
    prc_tmr_state_t tmr_next;

    ////////////////////////////////////////////////////////////////////////
    // count down from load, done in the last busy cycle
    always_comb begin
        tmr_next = tmr_reg;
        if (start) begin
            tmr_next.busy = 1'b1;
            tmr_next.cnt = LOAD;
        end else if (tmr_reg.busy) begin
            if (tmr_reg.cnt == '0) begin
                tmr_next.busy = 1'b0;
            end else begin
                tmr_next.cnt = tmr_reg.cnt - ONE;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            tmr_reg <= '0;
        end else begin
            tmr_reg <= tmr_next;
        end
    end

    assign busy = tmr_reg.busy;
    assign done = tmr_reg.busy && (tmr_reg.cnt == '0) && !start;

endmodule

// ---- verification/prc_host_model.sv ----
// prc_host_model: controller on the far side, driving the reset pin
// and the management port; assumes the bench calls tasks one at a time.
`timescale 1ns/10ps
module prc_host_model
    import prc_pkg::*;
(
    input wire logic core_clk,
    input wire prc_pkg::prc_word_t rd_data,
    output prc_pkg::prc_bus_req_t bus_req,
    output logic hw_reset_in_n
);
    // power-on: pin low, bus idle
    initial begin
        bus_req = '0;
        hw_reset_in_n = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // one-cycle strobes; released fields show inverted junk
    task automatic wr(input prc_addr_t a, input prc_word_t d);
        @(posedge core_clk);
        bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge core_clk);
        bus_req <= {2'b00, ~a, ~d};
    endtask

    task automatic rd(input prc_addr_t a, output prc_word_t d);
        @(posedge core_clk);
        bus_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
        @(posedge core_clk);
        bus_req <= {2'b00, ~a, 16'hffff};
        #1 d = rd_data;
    endtask

    task automatic hw_reset(input int n);
        @(posedge core_clk);
        hw_reset_in_n <= 1'b0;
        repeat (n) @(posedge core_clk);
        hw_reset_in_n <= 1'b1;
    endtask

    task automatic power_up(input int w1, input int w2, input int w3);
        hw_reset(2);
        repeat (w1) @(posedge core_clk);
        wr(PRC_REG_CTRL, 16'h4040);
        repeat (w2) @(posedge core_clk);
        hw_reset(w3);
    endtask
endmodule

// ---- verification/tb_top.sv ----
// tb_top: self-checking bench for the reset and power-down controller;
// assumes short timer parameters and the host model as bus master.
`timescale 1ns/10ps
module tb_top;
    import prc_pkg::*;
    localparam int SRST = 12;
    localparam int PDX = 10;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic hw_reset_in_n;
    logic hw_powerdown_pin = 1'b0;
    logic hw_pd_pll_select_strap = 1'b0;
    logic [PRC_CW-1:0] cfg_pins = 4'h0;
    logic line_energy_in = 1'b1;
    prc_bus_req_t bus_req;
    prc_word_t rd_data;
    prc_pwr_t pwr;
    logic strap_latched;
    logic [PRC_CW-1:0] cfg_latched;
    logic irq_n;
    int n_fail = 0;
    int samples_checked = 0;
    int seed = 32'hbd7a654c;
    int mdl [0:31];
    int cycles = 0;
    int n;
    prc_word_t rv;
    prc_word_t kv;
    logic [4:0] lat;
    prc_addr_t regs [6] = '{5'h00, 5'h11, 5'h1d, 5'h1e, 5'h1f, 5'h05};

    always #10 core_clk = ~core_clk;

    prc_reset_pd_ctrl #(.SRST_CYCLES(SRST), .PDX_CYCLES(PDX))
        i_prc_reset_pd_ctrl (.core_clk(core_clk), .rst_n(rst_n),
        .hw_reset_in_n(hw_reset_in_n), .hw_powerdown_pin(hw_powerdown_pin),
        .hw_pd_pll_select_strap(hw_pd_pll_select_strap),
        .cfg_pins(cfg_pins), .line_energy_in(line_energy_in),
        .bus_req(bus_req), .rd_data(rd_data), .pwr(pwr),
        .strap_latched(strap_latched), .cfg_latched(cfg_latched),
        .irq_n(irq_n));

    prc_host_model i_prc_host_model (.core_clk(core_clk), .rd_data(rd_data),
        .bus_req(bus_req), .hw_reset_in_n(hw_reset_in_n));

    ////////////////////////////////////////////////////////////////////////
    // compare, model and wait helpers
    task automatic chk_word(input prc_word_t got, input prc_word_t exp);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("Error at %0t: flag %b expected %b", $time, got, exp);
        end
    endtask

    task automatic rd_chk(input prc_addr_t a);
        i_prc_host_model.rd(a, rv);
        chk_word(rv, prc_word_t'(mdl[a]));
    endtask

    task automatic wr_m(input prc_addr_t a, input prc_word_t d);
        i_prc_host_model.wr(a, d);
        mdl[a] = d;
    endtask

    task automatic mdl_dflt();
        foreach (mdl[i]) mdl[i] = 0;
        mdl[17] = 2;
    endtask

    task automatic wait_rst(input logic v);
        n = 0;
        while (pwr.core_reset_n !== v && n < 500) begin
            @(posedge core_clk);
            #1 n++;
        end
        if (pwr.core_reset_n !== v) begin
            n_fail++;
            $display("Error at %0t: reset level wait ran out", $time);
        end
    endtask

    task automatic tally_and_finish();
        $display("checked %0d, failed %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // hang guard
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_fail++;
            tally_and_finish();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        cfg_pins = 4'($random(seed));
        repeat (20) @(posedge core_clk);
        rst_n <= 1'b1;
        i_prc_host_model.power_up(25, 100, 5);
        repeat (2) @(posedge core_clk);
        #1 chk_word(16'({cfg_latched, strap_latched}), 16'({cfg_pins, 1'b0}));
        mdl_dflt();
        foreach (regs[i]) rd_chk(regs[i]);
        // soft reset with exempt data and moved straps
        kv = 16'($random(seed));
        wr_m(PRC_REG_KEEP, kv);
        wr_m(PRC_REG_MASK, 16'h0080);
        lat = {cfg_pins, 1'b0};
        @(posedge core_clk);
        cfg_pins <= ~cfg_pins;
        hw_pd_pll_select_strap <= 1'b1;
        i_prc_host_model.wr(PRC_REG_CTRL, 16'h8000);
        repeat (2) @(posedge core_clk);
        #1 chk_bit(pwr.core_reset_n, 1'b0);
        mdl[0] = 32'h8000;
        rd_chk(PRC_REG_CTRL);
        wait_rst(1'b1);
        chk_bit(n >= SRST - 6, 1'b1);
        mdl[0] = 0;
        mdl[30] = 0;
        foreach (regs[i]) rd_chk(regs[i]);
        chk_word(16'({cfg_latched, strap_latched}), 16'(lat));
        // general power-down, registers live, timed wake
        wr_m(PRC_REG_CTRL, 16'h0800);
        repeat (3) @(posedge core_clk);
        #1 chk_word(16'(pwr), 16'(5'b10000));
        wr_m(PRC_REG_KEEP, 16'($random(seed)));
        wr_m(PRC_REG_CTRL, 16'h0000);
        wait_rst(1'b0);
        chk_word(16'(pwr), 16'(5'b01101));
        wait_rst(1'b1);
        chk_bit(n >= PDX, 1'b1);
        rd_chk(PRC_REG_KEEP);
        chk_word(16'({cfg_latched, strap_latched}), 16'(lat));
        // energy-detect sleep and wake
        wr_m(PRC_REG_MASK, 16'h0080);
        i_prc_host_model.wr(PRC_REG_EDCS, 16'h2000);
        mdl[17] = 32'h2002;
        @(posedge core_clk);
        line_energy_in <= 1'b0;
        repeat (4) @(posedge core_clk);
        #1 chk_word(16'(pwr), 16'(5'b10001));
        mdl[17] = 32'h2000;
        rd_chk(PRC_REG_EDCS);
        mdl[17] = 32'h2002;
        @(posedge core_clk);
        line_energy_in <= 1'b1;
        wait_rst(1'b0);
        chk_bit(irq_n, 1'b0);
        chk_bit(pwr.tx_en, 1'b0);
        wait_rst(1'b1);
        chk_bit(pwr.tx_en, 1'b1);
        mdl[29] = 32'h80;
        foreach (regs[i]) rd_chk(regs[i]);
        mdl[29] = 0;
        wr_m(PRC_REG_MASK, 16'h0000);
        rd_chk(PRC_REG_FLAG);
        chk_bit(irq_n, 1'b1);
        // pin power-down through hardware reset, both strap levels
        for (int s = 0; s < 2; s++) begin
            @(posedge core_clk);
            hw_pd_pll_select_strap <= s[0];
            hw_powerdown_pin <= 1'b1;
            i_prc_host_model.hw_reset(6);
            #1 chk_bit(pwr.core_reset_n, 1'b0);
            repeat (2) @(posedge core_clk);
            #1 chk_word(16'(pwr), 16'({2'b10, s[0], 2'b00}));
            chk_word(16'({cfg_latched, strap_latched}), 16'({cfg_pins, s[0]}));
            mdl_dflt();
            mdl[0] = 32'h0800;
            mdl[16] = 32'ha0 | (int'(cfg_pins) << 1) | s;
            rd_chk(PRC_REG_STAT);
            rd_chk(PRC_REG_CTRL);
            @(posedge core_clk);
            hw_powerdown_pin <= 1'b0;
            wr_m(PRC_REG_CTRL, 16'h0000);
            wait_rst(1'b0);
            wait_rst(1'b1);
            if (s == 0) begin
                i_prc_host_model.wr(PRC_REG_CTRL, 16'h8000);
                repeat (3) @(posedge core_clk);
                wait_rst(1'b1);
            end
            chk_word(16'(pwr), 16'(5'b11111));
        end
        tally_and_finish();
    end
endmodule
